// file: core/ready_hs_pkg.sv
// package for the data phase ready handshake block
// assumes a single bus clock and synchronous active-high reset
package ready_hs_pkg;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REG_WAIT_DEFAULT = 2;
  localparam int WAIT_CNT_W = 4;
  localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_RESET = 4'h0;
  localparam logic READY_IDLE = 1'b1;

  typedef enum logic [1:0] {
    ROLE_NONE,
    ROLE_INITIATOR,
    ROLE_TARGET
  } role_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be;
  } phase_word_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;
endpackage

// file: core/phase_hold.sv
// holds the data and byte enables of the driving party until phase end
// takes a new word only while no word is held; a load offered while held is ignored
`timescale 1ns/1ps
module phase_hold
  import ready_hs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic load,
  input wire phase_word_t load_word,
  input wire logic complete,
  output phase_word_t held_word,
  output logic held
);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      held <= 1'b0;
    end else if (clk_en) begin
      if (complete) begin
        held <= 1'b0;
      end else if (load) begin
        held <= 1'b1;
      end
    end
  end

  // word frozen until completion
  always_ff @(posedge core_clk) begin
    if (reset) begin
      held_word <= '0;
    end else if (clk_en && load && !held) begin
      held_word <= load_word;
    end
  end
endmodule

// file: core/ready_handshake.sv
// data phase ready handshake for a shared 32-bit bus, both roles
// assumes all pins synchronous to core_clk; pin wire resolved outside
// Operation
// - phase completes only when both ready lines sample low together
// - as target, hold target ready high until able to complete
// - as target on own registers, add extra wait cycles per phase
// - target ready is input as initiator, output as target
// - initiator ready is output as initiator, input as target
// - neither role: both ready lines left undriven
// - ready lines change and are sampled only on rising clock edges
// - as initiator, initiator ready high when not ready, low when ready
// - frame low over transaction; frame high marks last data phase
`timescale 1ns/1ps
module ready_handshake
  import ready_hs_pkg::*;
#(
  parameter int REG_WAIT = REG_WAIT_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire role_t role,
  input wire logic reg_access,
  input wire logic local_ready,
  input wire logic cycle_frame_n,
  input wire logic target_ready_n_in,
  output logic target_ready_n_out,
  output logic target_ready_n_oe,
  input wire logic initiator_ready_n_in,
  output logic initiator_ready_n_out,
  output logic initiator_ready_n_oe,
  input wire logic word_valid,
  input wire phase_word_t word_in,
  output phase_word_t word_out,
  output logic word_held,
  output logic phase_done,
  output logic last_phase_done
);
  logic [WAIT_CNT_W-1:0] wait_cnt;
  logic trdy_ready;
  logic irdy_ready;
  logic both_low;
  logic wait_over;
  logic active;

  localparam int LINES = 2;
  localparam role_t LINE_OWNER [LINES] = '{ROLE_TARGET, ROLE_INITIATOR};

  pin_drive_t drive [LINES];
  logic [LINES-1:0] line_ready;

  function automatic logic phase_ends(input logic t_n, input logic i_n);
    phase_ends = !t_n && !i_n;
  endfunction

  // role decode, shared by counter, ready flops and pin drive
  function automatic logic owns(input role_t r, input role_t owner);
    owns = r == owner;
  endfunction

  assign active = !cycle_frame_n || !target_ready_n_in ||
                  !initiator_ready_n_in || !trdy_ready || !irdy_ready;

  // ready lines as seen on the wire, sampled at core_clk rising edges
  assign both_low = phase_ends(target_ready_n_in, initiator_ready_n_in);
  assign phase_done = clk_en && both_low &&
                      role != ROLE_NONE;
  assign last_phase_done = phase_done && cycle_frame_n;

  assign wait_over = !reg_access ||
                     wait_cnt >= WAIT_CNT_W'(REG_WAIT);

  // per-phase wait counter for own register accesses
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_cnt <= WAIT_CNT_RESET;
    end else if (clk_en) begin
      if (!owns(role, ROLE_TARGET) || phase_done) begin
        wait_cnt <= WAIT_CNT_RESET;
      end else if (reg_access && !wait_over) begin
        wait_cnt <= wait_cnt + 1'b1;
      end
    end
  end

  // target ready, registered so it changes on edges only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trdy_ready <= 1'b0;
    end else if (clk_en) begin
      if (!owns(role, ROLE_TARGET) || phase_done) begin
        trdy_ready <= 1'b0;
      end else begin
        trdy_ready <= local_ready && wait_over;
      end
    end
  end

  // initiator ready, registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irdy_ready <= 1'b0;
    end else if (clk_en) begin
      if (!owns(role, ROLE_INITIATOR) || phase_done) begin
        irdy_ready <= 1'b0;
      end else begin
        irdy_ready <= local_ready;
      end
    end
  end

  assign line_ready[0] = trdy_ready;
  assign line_ready[1] = irdy_ready;

  // one drive per ready line, released unless its owning role is held
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      assign drive[g].oe = owns(role, LINE_OWNER[g]);
      assign drive[g].o = drive[g].oe ? !line_ready[g] : READY_IDLE;
    end
  endgenerate

  assign target_ready_n_oe = drive[0].oe;
  assign target_ready_n_out = drive[0].o;
  assign initiator_ready_n_oe = drive[1].oe;
  assign initiator_ready_n_out = drive[1].o;

  phase_hold u_hold (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .load(word_valid && active && role != ROLE_NONE),
    .load_word(word_in),
    .complete(phase_done),
    .held_word(word_out),
    .held(word_held)
  );
endmodule

// file: testbench/ready_handshake_chk.sv
// port checker for ready_handshake
// assumes phase_done is forced low while clk_en is low
`timescale 1ns/1ps
module rh_chk
  import ready_hs_pkg::*;
  #(parameter int REG_WAIT = REG_WAIT_DEFAULT) (
  input logic core_clk,
  input logic reset,
  input role_t role,
  input logic reg_access,
  input logic cycle_frame_n,
  input logic target_ready_n_in,
  input logic initiator_ready_n_in,
  input logic target_ready_n_out,
  input logic target_ready_n_oe,
  input logic initiator_ready_n_out,
  input logic initiator_ready_n_oe,
  input phase_word_t word_out,
  input logic word_held,
  input logic phase_done,
  input logic last_phase_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_done_both: assert property (phase_done |->
    !target_ready_n_in && !initiator_ready_n_in) else $error("done");
  a_trdy_dir: assert property (
    target_ready_n_oe == (role == ROLE_TARGET)) else $error("t oe");
  a_irdy_dir: assert property (
    initiator_ready_n_oe == (role == ROLE_INITIATOR)) else $error("i oe");
  a_trdy_back: assert property (phase_done &&
    role == ROLE_TARGET |=> target_ready_n_out) else $error("t back");
  a_irdy_back: assert property (phase_done &&
    role == ROLE_INITIATOR |=> initiator_ready_n_out) else $error("i back");
  a_reg_wait: assert property ($fell(target_ready_n_out) &&
    reg_access |-> $past(role, REG_WAIT + 1) == ROLE_TARGET)
    else $error("stretch");
  a_word_hold: assert property (word_held && !phase_done |=>
    word_held && $stable(word_out)) else $error("word");
  a_last_phase: assert property (
    last_phase_done == (phase_done && cycle_frame_n)) else $error("last");
  c_init: cover property (phase_done && role == ROLE_INITIATOR);
  c_tgt: cover property (phase_done && role == ROLE_TARGET);
  c_reg: cover property (phase_done && reg_access);
endmodule
bind ready_handshake rh_chk #(.REG_WAIT(REG_WAIT)) rh_chk_inst (.*);

// file: testbench/far_rdy.sv
// far-side ready model, the other party's ready line
// assumes released lines are pulled up
`timescale 1ns/1ps
module far_rdy
  import ready_hs_pkg::*; (
  input logic core_clk,
  input role_t role,
  input logic slow,
  input logic phase_done,
  output logic p_trdy_n,
  output logic p_irdy_n
);
  logic rdy_n = 1'b1;
  logic waited = 1'b0;
  always_ff @(posedge core_clk) begin
    waited <= role != ROLE_NONE && !phase_done;
    rdy_n <= role == ROLE_NONE || phase_done || (slow && !waited);
  end
  assign p_trdy_n = role == ROLE_INITIATOR ? rdy_n : 1'b1;
  assign p_irdy_n = role == ROLE_TARGET ? rdy_n : 1'b1;
endmodule

// file: testbench/ready_handshake_test.sv
// bench: ready_handshake facing the far-side ready model
// assumes default REG_WAIT; clk_en high except in the freeze test
`timescale 1ns/1ps
module ready_handshake_test;
  import ready_hs_pkg::*;
  logic core_clk = 0, reset = 1, reg_access = 0, local_ready = 0, slow = 0;
  logic cycle_frame_n = 1, word_valid = 0, p_trdy_n, p_irdy_n, word_held;
  logic clk_en = 1;
  logic target_ready_n_out, target_ready_n_oe, target_ready_n_in;
  logic initiator_ready_n_out, initiator_ready_n_oe, initiator_ready_n_in;
  logic phase_done, last_phase_done;
  role_t role = ROLE_NONE;
  phase_word_t word_in = '0, word_out;
  int errors = 0, comparisons = 0;
  assign target_ready_n_in = target_ready_n_oe ? target_ready_n_out : p_trdy_n;
  assign initiator_ready_n_in =
    initiator_ready_n_oe ? initiator_ready_n_out : p_irdy_n;
  ready_handshake ready_handshake_inst (.*);
  far_rdy far_rdy_inst (.*);
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(string n, logic [35:0] e, s);
    comparisons++;
    if (s !== e) $display("mismatch %s exp %h got %h", n, e, s);
    if (s !== e) errors++;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_phase(role_t r, logic ra, sl, int lat);
    int n;
    n = 0;
    @(posedge core_clk);
    role <= r;
    reg_access <= ra;
    slow <= sl;
    cycle_frame_n <= sl;
    local_ready <= 1;
    word_valid <= 1;
    word_in <= {32'hC3A50F00 | lat, 4'h9};
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!phase_done && n < 40);
    chk("cycles", lat, n);
    chk("word", word_in, word_out);
    chk("last", sl, last_phase_done);
    @(posedge core_clk);
    role <= ROLE_NONE;
    local_ready <= 0;
    word_valid <= 0;
    #1 chk("oe", 0, {target_ready_n_oe, initiator_ready_n_oe});
    if (n == 40) tally_and_finish;
    $display("test end role %0d", r);
  endtask
  task automatic t_freeze;
    @(posedge core_clk);
    clk_en <= 0;
    role <= ROLE_TARGET;
    local_ready <= 1;
    repeat (3) @(posedge core_clk);
    #1 chk("frozen", 1, target_ready_n_out);
    @(posedge core_clk);
    clk_en <= 1;
    role <= ROLE_NONE;
    local_ready <= 0;
    $display("test end freeze");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 0;
    t_phase(ROLE_INITIATOR, 0, 0, 1);
    t_phase(ROLE_INITIATOR, 0, 1, 2);
    t_phase(ROLE_TARGET, 0, 1, 2);
    t_phase(ROLE_TARGET, 1, 0, REG_WAIT_DEFAULT + 1);
    t_freeze;
    tally_and_finish;
  end
endmodule
